// ==== rf_port_pkg.sv ====
// Constants shared by the radio front-end control port.
package rf_port_pkg;
    // ----------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WORD = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_ANT = 8'h10;
    // ----------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------
    localparam int CTRL_FAM_LSB = 0;
    localparam int CTRL_TX = 2;
    localparam int CTRL_DIV = 3;
    localparam int CTRL_LNA = 4;
    localparam int CTRL_SAVE = 5;
    localparam int CTRL_VCO = 6;
    localparam int CTRL_RADIO_EN = 7;
    localparam int CTRL_PA = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    // ----------------------------------------------------------
    // Command and status fields
    // ----------------------------------------------------------
    localparam int CMD_LEN_LSB = 0;
    localparam int CMD_AGC = 8;
    localparam int ANT_TOGGLE = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_AGC_BUSY = 1;
    localparam int ST_AGC_DONE = 2;
    localparam int ST_EEPROM = 3;
    localparam int ST_AUX = 4;
    localparam int ST_ANT = 5;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [5:0] LEN_RESET = 6'h00;
    localparam logic [5:0] LEN_MAX = 6'h20;
    // ----------------------------------------------------------
    // Radio families and bus answers
    // ----------------------------------------------------------
    localparam logic [1:0] FAM_A = 2'h0;
    localparam logic [1:0] FAM_B = 2'h1;
    localparam logic [1:0] FAM_C = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Cycles after reset release before straps are caught.
    localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage

// ==== rf_frontend_control_port.sv ====
// Radio front-end control port with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none

module rf_frontend_control_port
    import rf_port_pkg::*;
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_rst, // PCI reset, sync, high
    input wire logic i_por, // power-on reset, sync, high
    input wire logic i_clk_link, // serial link clock
    input wire logic [7:0] i_awaddr, // write address
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [31:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // write strobes
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    output logic [1:0] o_bresp, // write response
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    input wire logic [7:0] i_araddr, // read address
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    output logic [31:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_rvalid, // read valid
    input wire logic i_rready, // read ready
    input wire logic i_ant_switch, // receiver changes antenna
    output logic o_rf_shift_clock, // serial clock
    output logic o_rf_serial_data_out, // serial data
    output logic o_rf_serial_enable_n, // serial enable
    input wire logic i_agc_done_in, // AGC done pin
    output logic o_agc_start_out, // AGC start pin
    output logic o_lna_gain_select, // LNA gain pin
    output logic o_antenna_select_pos, // antenna select +
    output logic o_antenna_select_neg, // antenna select -
    output logic o_txrx_switch_pos, // TX/RX switch +
    output logic o_txrx_switch_neg, // TX/RX switch -
    output logic o_power_amp_control, // PA enable
    output logic o_regulator_shutdown_out, // regulator off
    input wire logic i_vco_power_or_eeprom_size_strap, // pin in
    output logic o_vco_power_or_eeprom_size_strap, // pin out
    output logic o_vco_power_or_eeprom_size_strap_oe, // pin oe
    input wire logic i_radio_enable_or_aux_power_detect, // pin in
    output logic o_radio_enable_or_aux_power_detect, // pin out
    output logic o_radio_enable_or_aux_power_detect_oe // pin oe
);
    typedef enum logic [4:0] {
        L_IDLE = 5'b00001,
        L_SETUP = 5'b00010,
        L_RISE = 5'b00100,
        L_FALL = 5'b01000,
        L_END = 5'b10000
    } link_state_e;
    typedef enum logic [2:0] {
        A_IDLE = 3'b001,
        A_WAIT_LOW = 3'b010,
        A_WAIT_HIGH = 3'b100
    } agc_state_e;

    logic rst_any;
    logic [8:0] ctrl;
    logic [1:0] family;
    logic [31:0] word;
    logic [5:0] len;
    logic start_tgl, dn_m, dn_s, busy;
    logic aw_hold, w_hold, do_write;
    logic [7:0] aw_addr;
    logic [31:0] w_data, w_mask, wr_val;
    logic [3:0] w_strb;
    logic agc_m, agc_s;
    agc_state_e agc_state;
    logic ant;
    logic vs_m, vs_s, ax_m, ax_s;
    logic [1:0] strap_cnt;
    logic eeprom_large, eeprom_done, aux_power, aux_done;
    logic lrst_m, lrst, st_m, st_s, st_seen, done_tgl;
    link_state_e lstate;
    logic [5:0] cnt;
    logic [4:0] bit_idx;

    assign rst_any = i_rst | i_por;
    assign family = ctrl[CTRL_FAM_LSB +: 2];
    assign busy = start_tgl ^ dn_s;

    // ----------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------
    assign o_awready = !aw_hold && !o_bvalid;
    assign o_wready = !w_hold && !o_bvalid;
    assign o_arready = !o_rvalid;
    assign do_write = aw_hold && w_hold && !o_bvalid;
    assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_val = w_data & w_mask;

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_hold <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                o_bvalid <= 1'b1;
                if (aw_addr == ADDR_CTRL || aw_addr == ADDR_WORD ||
                    aw_addr == ADDR_CMD || aw_addr == ADDR_ANT)
                    o_bresp <= RESP_OKAY;
                else
                    o_bresp <= RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_rvalid <= 1'b1;
            o_rresp <= RESP_OKAY;
            if (i_araddr == ADDR_CTRL)
                o_rdata <= {23'h000000, ctrl};
            else if (i_araddr == ADDR_WORD)
                o_rdata <= word;
            else if (i_araddr == ADDR_CMD)
                o_rdata <= {26'h0000000, len};
            else if (i_araddr == ADDR_STAT)
                o_rdata <= {26'h0000000, ant, aux_power, eeprom_large,
                            agc_s, agc_state != A_IDLE, busy};
            else if (i_araddr == ADDR_ANT)
                o_rdata <= 32'h0000_0000;
            else
            begin
                o_rdata <= 32'h0000_0000;
                o_rresp <= RESP_SLVERR;
            end
        end
        else if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
    end

    // ----------------------------------------------------------
    // Control, word and command registers
    // ----------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
            ctrl <= CTRL_RESET;
        else if (do_write && aw_addr == ADDR_CTRL)
            ctrl <= (ctrl & ~w_mask[8:0]) | wr_val[8:0];
    end

    // The link domain reads word and length while busy, so both are
    // frozen until the frame has ended.
    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            word <= WORD_RESET;
            len <= LEN_RESET;
            start_tgl <= 1'b0;
        end
        else if (do_write && !busy)
        begin
            if (aw_addr == ADDR_WORD)
                word <= (word & ~w_mask) | wr_val;
            else if (aw_addr == ADDR_CMD && w_strb[0] &&
                     w_data[5:0] != 6'h00 && w_data[5:0] <= LEN_MAX)
            begin
                len <= w_data[CMD_LEN_LSB +: 6];
                start_tgl <= ~start_tgl;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            dn_m <= 1'b0;
            dn_s <= 1'b0;
        end
        else
        begin
            dn_m <= done_tgl;
            dn_s <= dn_m;
        end
    end

    // ----------------------------------------------------------
    // AGC start handshake
    // ----------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        agc_m <= i_agc_done_in;
        agc_s <= agc_m;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any || family != FAM_C)
            agc_state <= A_IDLE;
        else
            case (agc_state)
                A_IDLE:
                    if (do_write && aw_addr == ADDR_CMD && w_strb[1] &&
                        w_data[CMD_AGC])
                        agc_state <= A_WAIT_LOW;
                A_WAIT_LOW:
                    if (!agc_s)
                        agc_state <= A_WAIT_HIGH;
                A_WAIT_HIGH:
                    if (agc_s)
                        agc_state <= A_IDLE;
                default:
                    agc_state <= A_IDLE;
            endcase
    end

    // ----------------------------------------------------------
    // Antenna diversity
    // ----------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
            ant <= 1'b0;
        else if (ctrl[CTRL_DIV] && (i_ant_switch || (do_write &&
                 aw_addr == ADDR_ANT && w_strb[0] && w_data[ANT_TOGGLE])))
            ant <= ~ant;
    end

    // ----------------------------------------------------------
    // Straps
    // ----------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        vs_m <= i_vco_power_or_eeprom_size_strap;
        vs_s <= vs_m;
        ax_m <= i_radio_enable_or_aux_power_detect;
        ax_s <= ax_m;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
            strap_cnt <= 2'h0;
        else if (strap_cnt != STRAP_WAIT)
            strap_cnt <= strap_cnt + 2'h1;
    end

    // The size strap survives a PCI reset; only power-on clears it.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_por)
        begin
            eeprom_done <= 1'b0;
            eeprom_large <= 1'b0;
        end
        else if (!i_rst && !eeprom_done && strap_cnt == STRAP_WAIT)
        begin
            eeprom_done <= 1'b1;
            eeprom_large <= vs_s;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            aux_done <= 1'b0;
            aux_power <= 1'b0;
        end
        else if (!aux_done && strap_cnt == STRAP_WAIT)
        begin
            aux_done <= 1'b1;
            aux_power <= ax_s;
        end
    end

    // ----------------------------------------------------------
    // Pin drives
    // ----------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (rst_any)
        begin
            o_agc_start_out <= 1'b0;
            o_lna_gain_select <= 1'b0;
            o_antenna_select_pos <= 1'b0;
            o_antenna_select_neg <= 1'b0;
            o_txrx_switch_pos <= 1'b0;
            o_txrx_switch_neg <= 1'b0;
            o_power_amp_control <= 1'b0;
            o_regulator_shutdown_out <= 1'b0;
        end
        else
        begin
            o_agc_start_out <= agc_state != A_IDLE;
            o_lna_gain_select <= family == FAM_B && ctrl[CTRL_LNA];
            o_antenna_select_pos <= ant;
            o_antenna_select_neg <= family != FAM_B && !ant;
            o_txrx_switch_pos <= family != FAM_B && ctrl[CTRL_TX];
            o_txrx_switch_neg <= family != FAM_B && !ctrl[CTRL_TX];
            o_power_amp_control <= ctrl[CTRL_PA];
            o_regulator_shutdown_out <= family == FAM_B && ctrl[CTRL_SAVE];
        end
    end

    assign o_vco_power_or_eeprom_size_strap = ctrl[CTRL_VCO];
    assign o_vco_power_or_eeprom_size_strap_oe = eeprom_done;
    assign o_radio_enable_or_aux_power_detect = ctrl[CTRL_RADIO_EN];
    assign o_radio_enable_or_aux_power_detect_oe = aux_done;

    // ----------------------------------------------------------
    // Serial link engine on the link clock
    // ----------------------------------------------------------
    // Reset enters the link domain at once and leaves it on link edges.
    always_ff @(posedge i_clk_link or posedge rst_any)
    begin
        if (rst_any)
        begin
            lrst_m <= 1'b1;
            lrst <= 1'b1;
            st_m <= 1'b0;
            st_s <= 1'b0;
        end
        else
        begin
            lrst_m <= 1'b0;
            lrst <= lrst_m;
            st_m <= start_tgl;
            st_s <= st_m;
        end
    end

    assign bit_idx = 5'(cnt - 6'h01);

    always_ff @(posedge i_clk_link or posedge lrst)
    begin
        if (lrst)
        begin
            lstate <= L_IDLE;
            st_seen <= 1'b0;
            done_tgl <= 1'b0;
            cnt <= 6'h00;
            o_rf_shift_clock <= 1'b0;
            o_rf_serial_data_out <= 1'b0;
            o_rf_serial_enable_n <= 1'b1;
        end
        else
            case (lstate)
                L_IDLE:
                begin
                    o_rf_serial_enable_n <= 1'b1;
                    o_rf_shift_clock <= 1'b0;
                    if (st_s != st_seen)
                    begin
                        st_seen <= st_s;
                        cnt <= len;
                        lstate <= L_SETUP;
                    end
                end
                L_SETUP:
                begin
                    o_rf_serial_enable_n <= 1'b0;
                    o_rf_serial_data_out <= word[bit_idx];
                    lstate <= L_RISE;
                end
                L_RISE:
                begin
                    o_rf_shift_clock <= 1'b1;
                    cnt <= cnt - 6'h01;
                    lstate <= L_FALL;
                end
                L_FALL:
                begin
                    o_rf_shift_clock <= 1'b0;
                    lstate <= (cnt == 6'h00) ? L_END : L_SETUP;
                end
                L_END:
                begin
                    o_rf_serial_enable_n <= 1'b1;
                    done_tgl <= ~done_tgl;
                    lstate <= L_IDLE;
                end
                default:
                    lstate <= L_IDLE;
            endcase
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    a_data_stable_high: assert property (
        @(posedge i_clk_link) disable iff (lrst)
        o_rf_shift_clock |=> $stable(o_rf_serial_data_out))
        else $error("serial data moved while shift clock high");
    a_enable_idle_high: assert property (
        @(posedge i_clk_link) disable iff (lrst)
        lstate == L_IDLE |-> o_rf_serial_enable_n && !o_rf_shift_clock)
        else $error("serial enable low or clock high while idle");
    a_rise_under_enable: assert property (
        @(posedge i_clk_link) disable iff (lrst)
        $rose(o_rf_shift_clock) |-> !o_rf_serial_enable_n)
        else $error("shift clock rose with enable high");
    a_agc_start_rise: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        agc_state == A_IDLE ##1 agc_state == A_WAIT_LOW
        |=> o_agc_start_out)
        else $error("AGC start did not rise");
    a_agc_done_drop: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        agc_state == A_WAIT_HIGH && agc_s && family == FAM_C
        |=> ##1 !o_agc_start_out)
        else $error("AGC start held after done");
    a_switch_compl: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        family != FAM_B ##1 family != FAM_B
        |-> o_txrx_switch_pos == $past(ctrl[CTRL_TX]) &&
            o_txrx_switch_neg != o_txrx_switch_pos)
        else $error("switch pair not complementary");
    a_ant_toggle: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        i_ant_switch && ctrl[CTRL_DIV] |=> ##1
        o_antenna_select_pos != $past(o_antenna_select_pos))
        else $error("antenna select did not toggle");
    a_reg_shutdown: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        family == FAM_B && ctrl[CTRL_SAVE] |=> o_regulator_shutdown_out)
        else $error("regulator not shut down in power save");
    a_famb_unused: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        family == FAM_B |=> !o_txrx_switch_pos && !o_txrx_switch_neg &&
        !o_antenna_select_neg && !o_agc_start_out)
        else $error("unused family B pin driven high");
    a_famc_lna_low: assert property (
        @(posedge i_clk_sys) disable iff (rst_any)
        family == FAM_C |=> !o_lna_gain_select)
        else $error("LNA gain driven in family C");
    a_eeprom_kept: assert property (
        @(posedge i_clk_sys) disable iff (i_por)
        eeprom_done |=> eeprom_done && $stable(eeprom_large))
        else $error("EEPROM size strap changed after capture");

endmodule // rf_frontend_control_port

`default_nettype wire

// ==== rf_radio_model.sv ====
// Behavioural radio front-end at the far side of the control port.
`timescale 1ns/1ps
`default_nettype none
module rf_radio_model #(parameter int AGC_NS = 400) (
    input wire logic i_sck, // shift clock
    input wire logic i_sd, // serial data
    input wire logic i_le_n, // serial enable, active low
    input wire logic i_agc_start, // AGC start level
    output logic o_agc_done = 1'b0, // AGC done level
    output logic [31:0] o_word = '0, // last word taken
    output logic [5:0] o_count = '0, // bits in last word
    output logic o_fault = 1'b0 // data moved while clock high
);
    logic [31:0] shift = '0;
    logic [5:0] count = '0;
    // ----------------------------------------------------------
    // Shift register and gain loop
    // ----------------------------------------------------------
    // Edges seen with the enable high must leave the contents alone.
    always @(posedge i_sck or posedge i_le_n)
    begin
        if (i_le_n)
        begin
            if (count != 6'h00)
            begin
                o_word <= shift;
                o_count <= count;
            end
            shift <= '0;
            count <= 6'h00;
        end
        else
        begin
            shift <= {shift[30:0], i_sd};
            count <= count + 6'h01;
        end
    end
    always @(posedge i_agc_start)
    begin
        o_agc_done <= 1'b0;
        #(AGC_NS) o_agc_done <= 1'b1;
    end
    always @(i_sd)
    begin
        if (i_sck && !i_le_n)
            o_fault <= 1'b1;
    end
endmodule // rf_radio_model
`default_nettype wire

// ==== test_rf_frontend_control_port.sv ====
// Register-level testbench of the radio front-end control port.
`timescale 1ns/1ps
`default_nettype none
module test_rf_frontend_control_port;
    import rf_port_pkg::*;
    logic i_clk_sys = 0, i_clk_link = 0, i_rst = 1, i_por = 1, i_ant_switch = 0;
    logic [7:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, o_rdata, word_seen;
    logic [3:0] i_wstrb = '0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, data_fault;
    logic [1:0] o_bresp, o_rresp;
    logic [5:0] count_seen;
    logic o_rf_shift_clock, o_rf_serial_data_out, o_rf_serial_enable_n, o_agc_start_out;
    logic o_lna_gain_select, o_antenna_select_pos, o_antenna_select_neg, o_txrx_switch_pos;
    logic o_txrx_switch_neg, o_power_amp_control, o_regulator_shutdown_out, i_agc_done_in;
    logic o_vco_power_or_eeprom_size_strap, o_vco_power_or_eeprom_size_strap_oe;
    logic o_radio_enable_or_aux_power_detect, o_radio_enable_or_aux_power_detect_oe;
    logic eep = 1, aux = 0;
    int n_mismatch = 0, check_count = 0;
    // The strap resistors set the pin level until the port drives it.
    wire logic i_vco_power_or_eeprom_size_strap = o_vco_power_or_eeprom_size_strap_oe ?
        o_vco_power_or_eeprom_size_strap : eep;
    wire logic i_radio_enable_or_aux_power_detect = o_radio_enable_or_aux_power_detect_oe ?
        o_radio_enable_or_aux_power_detect : aux;
    wire logic [6:0] pins = {o_power_amp_control, o_lna_gain_select, o_regulator_shutdown_out,
        o_txrx_switch_pos, o_txrx_switch_neg, o_antenna_select_pos, o_antenna_select_neg};
    logic [31:0] words [3] = '{32'h1234_56A5, 32'h8000_0001, 32'h0000_0001};
    logic [5:0] lens [3] = '{6'h08, 6'h20, 6'h01};
    always #5 i_clk_sys = ~i_clk_sys;
    initial
    begin
        #3;
        forever #80 i_clk_link = ~i_clk_link;
    end
    rf_frontend_control_port dut_u (.i_clk_sys, .i_rst, .i_por, .i_clk_link, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .i_ant_switch, .o_rf_shift_clock, .o_rf_serial_data_out, .o_rf_serial_enable_n,
        .i_agc_done_in, .o_agc_start_out, .o_lna_gain_select, .o_antenna_select_pos,
        .o_antenna_select_neg, .o_txrx_switch_pos, .o_txrx_switch_neg, .o_power_amp_control,
        .o_regulator_shutdown_out, .i_vco_power_or_eeprom_size_strap,
        .o_vco_power_or_eeprom_size_strap, .o_vco_power_or_eeprom_size_strap_oe,
        .i_radio_enable_or_aux_power_detect, .o_radio_enable_or_aux_power_detect,
        .o_radio_enable_or_aux_power_detect_oe);
    rf_radio_model radio_u (.i_sck(o_rf_shift_clock), .i_sd(o_rf_serial_data_out),
        .i_le_n(o_rf_serial_enable_n), .i_agc_start(o_agc_start_out), .o_agc_done(i_agc_done_in),
        .o_word(word_seen), .o_count(count_seen), .o_fault(data_fault));
    // ----------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask
    // Ready is sampled at the falling edge, where it already shows its rising-edge value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        int n;
        aw = 1;
        w = 1;
        b = 0;
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hF;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; !b && n < 100; n++)
        begin
            @(negedge i_clk_sys);
            aw = aw && !o_awready;
            w = w && !o_wready;
            b = o_bvalid;
            @(posedge i_clk_sys);
            i_awvalid <= aw;
            i_wvalid <= w;
            i_bready <= !b;
        end
        check("write response", RESP_OKAY, b ? o_bresp : 2'h3);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        int n;
        ar = 1;
        v = 0;
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; !v && n < 100; n++)
        begin
            @(negedge i_clk_sys);
            ar = ar && !o_arready;
            v = o_rvalid;
            d = o_rdata;
            r = v ? o_rresp : 2'h3;
            @(posedge i_clk_sys);
            i_arvalid <= ar;
            i_rready <= !v;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check($sformatf("register %h", a), e, d);
        check("read response", RESP_OKAY, r);
    endtask
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        d = 1;
        for (int n = 0; d[ST_BUSY] !== 1'b0 && n < 1000; n++)
            rd(ADDR_STAT, d, r);
        check("busy", 0, d[ST_BUSY]);
    endtask
    task automatic settle();
        repeat (3) @(posedge i_clk_sys);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #400_000;
        n_mismatch++;
        give_verdict();
    end
    // ----------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        i_por <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        rc(ADDR_CTRL, 32'h0000_0000);
        rc(ADDR_STAT, 32'h0000_0008);
        check("strap drive", 2'b11, {o_vco_power_or_eeprom_size_strap_oe,
            o_radio_enable_or_aux_power_detect_oe});
        rd(8'h20, d, r);
        check("unmapped response", RESP_SLVERR, r);
        check("pins", 7'b0000101, pins);
        wr(ADDR_CTRL, 32'h0000_000C);
        settle();
        check("pins", 7'b0001001, pins);
        @(posedge i_clk_sys);
        i_ant_switch <= 1'b1;
        @(posedge i_clk_sys);
        i_ant_switch <= 1'b0;
        settle();
        check("pins", 7'b0001010, pins);
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_WORD, words[k]);
            wr(ADDR_CMD, {26'h0, lens[k]});
            wait_idle();
            check("word", words[k] & 32'((64'h1 << lens[k]) - 64'h1), word_seen);
            check("bits", lens[k], count_seen);
            check("idle", 2'b10, {o_rf_serial_enable_n, o_rf_shift_clock});
        end
        wr(ADDR_CMD, 32'h0000_0000);
        wr(ADDR_CMD, 32'h0000_0021);
        wait_idle();
        check("bits", 6'h01, count_seen);
        check("data edge", 0, data_fault);
        wr(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_CMD, 32'h0000_0100);
        for (n = 0; n < 50 && o_agc_start_out !== 1'b1; n++)
            @(posedge i_clk_sys);
        check("agc start", 1, o_agc_start_out);
        for (n = 0; n < 200 && o_agc_start_out !== 1'b0; n++)
            @(posedge i_clk_sys);
        check("agc end", 2'b10, {i_agc_done_in, o_agc_start_out});
        check("agc held", 1, n >= 40);
        wr(ADDR_CTRL, 32'h0000_0035);
        wr(ADDR_CMD, 32'h0000_0100);
        repeat (10) @(posedge i_clk_sys);
        check("agc start", 0, o_agc_start_out);
        check("pins", 7'b0110010, pins);
        wr(ADDR_CTRL, 32'h0000_01F6);
        settle();
        check("pins", 7'b1001010, pins);
        check("strap pins", 2'b11, {o_vco_power_or_eeprom_size_strap,
            o_radio_enable_or_aux_power_detect});
        eep <= 1'b0;
        aux <= 1'b1;
        i_rst <= 1'b1;
        repeat (120) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        rc(ADDR_STAT, 32'h0000_001C);
        check("pins", 7'b0000101, pins);
        give_verdict();
    end
endmodule // test_rf_frontend_control_port
`default_nettype wire
